// ---- logic/kme_consts.svh ----
`ifndef KME_CONSTS_SVH
`define KME_CONSTS_SVH
`define KME_DRIVE_LINES     11
`define KME_SENSE_LINES     8
`define KME_CODE_BITS       8
`define KME_PRESS_DEB       4
`define KME_RELEASE_DEB     16
`define KME_MOD_DEB         4
`define KME_CS_ACTIVE       4'b1111
`define KME_HEX_BIT         8'h80
`define KME_CTRL_MASK       8'h1f
`define KME_SHIFT_FLIP      8'h10
`define KME_ALPHA_FLIP      8'h20
`define KME_ASCII_BASE      8'h20
`define KME_HEX_FIRST       5'h07
`define KME_ALPHA_FIRST     3'h2
`define KME_ALPHA_LAST      3'h5
`define KME_DEB_MAX         65536
`endif

// ---- logic/kme_pkg.sv ----
package kme_pkg;
  typedef enum logic [3:0] {
    KME_SCAN    = 4'b0001,
    KME_PRESS   = 4'b0010,
    KME_HELD    = 4'b0100,
    KME_RELEASE = 4'b1000
  } kme_state_t;
endpackage

// ---- logic/kme_code_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "kme_consts.svh"
module kme_code_rom (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [4:0] drive_idx,
  input  wire logic [2:0] sense_idx,
  input  wire logic       shift_mod,
  input  wire logic       control_mod,
  input  wire logic       alpha_mod,
  output logic      [7:0] code_q
);
  logic [1:0] hex_row;
  logic [7:0] code_d;
  always_comb begin
    hex_row = 2'(drive_idx - `KME_HEX_FIRST);
    if (drive_idx >= `KME_HEX_FIRST) begin
      // Last four drive lines form the hex block
      code_d = `KME_HEX_BIT | {3'b000, hex_row, sense_idx};
    end else begin
      code_d = `KME_ASCII_BASE + {2'b00, drive_idx[2:0], sense_idx};
      if (shift_mod) begin
        code_d = code_d ^ `KME_SHIFT_FLIP;
      end
      if (alpha_mod && drive_idx[2:0] >= `KME_ALPHA_FIRST &&
          drive_idx[2:0] <= `KME_ALPHA_LAST) begin
        code_d = code_d & ~`KME_ALPHA_FLIP;
      end
      if (control_mod) begin
        code_d = code_d & `KME_CTRL_MASK;
      end
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      code_q <= 8'h00;
    end else begin
      code_q <= code_d;
    end
  end
endmodule
`default_nettype wire

// ---- logic/kme_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "kme_consts.svh"
module kme_encoder #(
  parameter int DRIVES      = `KME_DRIVE_LINES,
  parameter int SENSES      = `KME_SENSE_LINES,
  parameter int PRESS_DEB   = `KME_PRESS_DEB,
  parameter int RELEASE_DEB = `KME_RELEASE_DEB,
  parameter int MOD_DEB     = `KME_MOD_DEB
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        timing_pulse,
  input  wire logic [3:0]  chip_select_inputs,
  input  wire logic [7:0]  matrix_sense_lines,
  input  wire logic        shift_in,
  input  wire logic        control_in,
  input  wire logic        alpha_in,
  output logic      [10:0] matrix_drive_lines,
  output logic      [7:0]  bus_data_out,
  output logic      [7:0]  bus_data_oe,
  output logic             key_ready_n,
  output logic             key_repeat_n,
  output logic             debounce_discharge
);
  // Ports and counters are sized for the eleven by eight matrix
  if (DRIVES != `KME_DRIVE_LINES || SENSES != `KME_SENSE_LINES ||
      PRESS_DEB < 1 || RELEASE_DEB < 1 || MOD_DEB < 1 || PRESS_DEB > `KME_DEB_MAX ||
      RELEASE_DEB > `KME_DEB_MAX || MOD_DEB > `KME_DEB_MAX) begin : g_bad_params
    $error("kme_encoder: unsupported parameters");
  end

  kme_pkg::kme_state_t state_q, state_d;
  logic [4:0]  drive_q, drive_d;
  logic [2:0]  sense_q, sense_d;
  logic [15:0] deb_q, deb_d;
  logic [15:0] mod_cnt_q, mod_cnt_d;
  logic        tp_q;
  logic        ready_n_q, ready_n_d;
  logic        rpt_n_q, rpt_n_d;
  logic        read_q, read_d;
  logic        shift_q, shift_d, ctrl_q, ctrl_d;
  logic [10:0] drv_out_d;
  logic [7:0]  oe_d;
  logic        discharge_d;
  logic [7:0]  code;
  logic        tp_fall, tp_rise, selected, key_closed;

  assign tp_fall    = tp_q && !timing_pulse;
  assign tp_rise    = !tp_q && timing_pulse;
  assign selected   = chip_select_inputs == `KME_CS_ACTIVE;
  assign key_closed = matrix_sense_lines[sense_q];

  // Lookup of drive, sense and modifiers into the key code
  kme_code_rom u_rom (
    .clock       (clock),
    .nrst        (nrst),
    .drive_idx   (drive_q),
    .sense_idx   (sense_q),
    .shift_mod   (shift_q),
    .control_mod (ctrl_q),
    .alpha_mod   (alpha_in),
    .code_q      (code)
  );

  always_comb begin
    state_d   = state_q;
    drive_d   = drive_q;
    sense_d   = sense_q;
    deb_d     = deb_q;
    ready_n_d = ready_n_q;
    rpt_n_d   = rpt_n_q;
    read_d    = read_q;
    if (selected && tp_rise && !ready_n_q) begin
      ready_n_d = 1'b1;
      read_d    = 1'b1;
      if (key_closed) begin
        rpt_n_d = 1'b0;
      end
    end
    unique case (state_q)
      kme_pkg::KME_SCAN: begin
        if (key_closed) begin
          state_d = kme_pkg::KME_PRESS;
          deb_d   = 16'h0000;
        end else if (tp_fall) begin
          if (sense_q == 3'(SENSES - 1)) begin
            sense_d = 3'h0;
            drive_d = (drive_q == 5'(DRIVES - 1)) ? 5'h00 : drive_q + 5'h01;
          end else begin
            sense_d = sense_q + 3'h1;
          end
        end
      end
      kme_pkg::KME_PRESS: begin
        if (!key_closed) begin
          state_d = kme_pkg::KME_SCAN;
        end else if (tp_rise) begin
          if (deb_q >= 16'(PRESS_DEB - 1)) begin
            state_d   = kme_pkg::KME_HELD;
            ready_n_d = 1'b0;
            read_d    = 1'b0;
          end else begin
            deb_d = deb_q + 16'h0001;
          end
        end
      end
      kme_pkg::KME_HELD: begin
        if (!key_closed) begin
          state_d = kme_pkg::KME_RELEASE;
          deb_d   = 16'h0000;
        end
      end
      kme_pkg::KME_RELEASE: begin
        if (key_closed) begin
          state_d = kme_pkg::KME_HELD;
        end else if (tp_rise) begin
          if (deb_q >= 16'(RELEASE_DEB - 1)) begin
            rpt_n_d = 1'b1;
            if (read_q || (selected && !ready_n_q)) begin
              state_d = kme_pkg::KME_SCAN;
            end
          end else begin
            deb_d = deb_q + 16'h0001;
          end
        end
      end
    endcase
  end

  // Shift and control latch after their own debounce
  always_comb begin
    mod_cnt_d = mod_cnt_q;
    shift_d   = shift_q;
    ctrl_d    = ctrl_q;
    if (!(shift_in || control_in)) begin
      mod_cnt_d = 16'h0000;
      if (state_q == kme_pkg::KME_SCAN) begin
        shift_d = 1'b0;
        ctrl_d  = 1'b0;
      end
    end else if (tp_rise) begin
      if (mod_cnt_q >= 16'(MOD_DEB - 1)) begin
        shift_d = shift_q | shift_in;
        ctrl_d  = ctrl_q | control_in;
      end else begin
        mod_cnt_d = mod_cnt_q + 16'h0001;
      end
    end
  end

  // One-hot decode of the drive counter
  for (genvar g = 0; g < `KME_DRIVE_LINES; g++) begin : g_drive
    assign drv_out_d[g] = drive_d == 5'(g);
  end

  always_comb begin
    oe_d        = selected ? 8'hff : 8'h00;
    discharge_d = (state_d == kme_pkg::KME_PRESS) || (state_d == kme_pkg::KME_HELD);
  end

  // Scan and handshake state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q   <= kme_pkg::KME_SCAN;
      drive_q   <= 5'h00;
      sense_q   <= 3'h0;
      deb_q     <= 16'h0000;
      // Pulse idles low, so no false edge follows reset
      tp_q      <= 1'b0;
      ready_n_q <= 1'b1;
      rpt_n_q   <= 1'b1;
      read_q    <= 1'b1;
    end else begin
      state_q   <= state_d;
      drive_q   <= drive_d;
      sense_q   <= sense_d;
      deb_q     <= deb_d;
      tp_q      <= timing_pulse;
      ready_n_q <= ready_n_d;
      rpt_n_q   <= rpt_n_d;
      read_q    <= read_d;
    end
  end

  // Modifier latches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mod_cnt_q <= 16'h0000;
      shift_q   <= 1'b0;
      ctrl_q    <= 1'b0;
    end else begin
      mod_cnt_q <= mod_cnt_d;
      shift_q   <= shift_d;
      ctrl_q    <= ctrl_d;
    end
  end

  // Registered pins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      matrix_drive_lines <= 11'h001;
      bus_data_oe        <= 8'h00;
      bus_data_out       <= 8'h00;
      key_ready_n        <= 1'b1;
      key_repeat_n       <= 1'b1;
      debounce_discharge <= 1'b0;
    end else begin
      matrix_drive_lines <= drv_out_d;
      bus_data_oe        <= oe_d;
      bus_data_out       <= code;
      key_ready_n        <= ready_n_d;
      key_repeat_n       <= rpt_n_d;
      debounce_discharge <= discharge_d;
    end
  end

  scan_frozen_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q != kme_pkg::KME_SCAN) |=> $stable(drive_q) && $stable(sense_q))
    else $error("scan moved while frozen");
  bus_select_a: assert property (@(posedge clock) disable iff (!nrst)
    !selected |=> bus_data_oe == 8'h00)
    else $error("bus driven while unselected");
  bus_on_a: assert property (@(posedge clock) disable iff (!nrst)
    selected |=> bus_data_oe == 8'hff)
    else $error("bus not driven while selected");
  ready_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (selected && tp_rise && !ready_n_q) |=> key_ready_n)
    else $error("ready not cleared on read");
  ready_once_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_HELD && ready_n_q) |=> ready_n_q)
    else $error("ready reasserted while held");
  ready_src_a: assert property (@(posedge clock) disable iff (!nrst)
    (ready_n_q && !ready_n_d) |-> state_q == kme_pkg::KME_PRESS)
    else $error("ready set outside key debounce");
  press_ready_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_PRESS && key_closed && tp_rise && deb_q >= 16'(PRESS_DEB - 1))
    |=> !key_ready_n)
    else $error("ready not set after press debounce");
  repeat_set_a: assert property (@(posedge clock) disable iff (!nrst)
    (selected && tp_rise && !ready_n_q && key_closed) |=> !key_repeat_n)
    else $error("repeat not raised");
  repeat_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_HELD && key_closed && !key_repeat_n) |=> !key_repeat_n)
    else $error("repeat dropped while key held");
  repeat_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_RELEASE && !key_closed && tp_rise &&
     deb_q >= 16'(RELEASE_DEB - 1)) |=> key_repeat_n)
    else $error("repeat not released");
  resume_read_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_RELEASE && !read_q && !selected) |=> state_q != kme_pkg::KME_SCAN)
    else $error("scan resumed before read");
  lock_held_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_HELD) |=> state_q != kme_pkg::KME_SCAN)
    else $error("held key lost its lock");
  one_drive_a: assert property (@(posedge clock) disable iff (!nrst)
    $onehot(matrix_drive_lines))
    else $error("drive lines not one-hot");
  drive_match_a: assert property (@(posedge clock) disable iff (!nrst)
    matrix_drive_lines == (11'h001 << drive_q))
    else $error("drive line does not follow counter");
  scan_step_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_SCAN && !key_closed && tp_fall && sense_q != 3'h7)
    |=> sense_q == 3'($past(sense_q) + 3'h1))
    else $error("sense counter did not step");
  sense_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_SCAN && !key_closed && tp_fall && sense_q == 3'h7)
    |=> sense_q == 3'h0)
    else $error("sense counter wrap wrong");
  discharge_out_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_HELD) |-> debounce_discharge)
    else $error("discharge off while held");
  release_charge_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == kme_pkg::KME_RELEASE) |-> !debounce_discharge)
    else $error("discharge on during release");
  cov_press_c: cover property (@(posedge clock) disable iff (!nrst) $fell(key_ready_n));
  cov_read_c: cover property (@(posedge clock) disable iff (!nrst) $rose(key_ready_n));
  cov_repeat_c: cover property (@(posedge clock) disable iff (!nrst) $fell(key_repeat_n));
  cov_late_read_c: cover property (@(posedge clock) disable iff (!nrst)
    state_q == kme_pkg::KME_RELEASE && selected && tp_rise && !ready_n_q);
  cov_resume_c: cover property (@(posedge clock) disable iff (!nrst)
    state_q == kme_pkg::KME_RELEASE ##1 state_q == kme_pkg::KME_SCAN);
endmodule
`default_nettype wire

// ---- testbench/kme_matrix_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module kme_matrix_model (
  input  wire logic [10:0] matrix_drive_lines,
  input  wire logic [87:0] key_mask,
  output logic      [7:0]  matrix_sense_lines
);
  // Open switches leave a sense line at its pull-down level
  always_comb begin
    matrix_sense_lines = 8'h00;
    for (int d = 0; d < 11; d++) begin
      for (int s = 0; s < 8; s++) begin
        if (matrix_drive_lines[d] && key_mask[d*8+s]) begin
          matrix_sense_lines[s] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/kme_encoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module kme_encoder_tb;
  logic        clock        = 1'b0;
  logic        nrst         = 1'b0;
  logic        timing_pulse = 1'b0;
  logic [3:0]  cs           = 4'h0;
  logic        shift_in     = 1'b0;
  logic        control_in   = 1'b0;
  logic        alpha_in     = 1'b0;
  logic [87:0] key_mask     = '0;
  logic [7:0]  sense;
  logic [10:0] drive;
  logic [7:0]  dout;
  logic [7:0]  doe;
  logic        rdy_n;
  logic        rpt_n;
  logic        dis;
  logic [10:0] seen_or;
  int          n_errors     = 0;
  int          num_checks   = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  kme_encoder #(.PRESS_DEB(2), .RELEASE_DEB(2), .MOD_DEB(1)) dut (
    .clock(clock), .nrst(nrst), .timing_pulse(timing_pulse),
    .chip_select_inputs(cs), .matrix_sense_lines(sense),
    .shift_in(shift_in), .control_in(control_in), .alpha_in(alpha_in),
    .matrix_drive_lines(drive), .bus_data_out(dout), .bus_data_oe(doe),
    .key_ready_n(rdy_n), .key_repeat_n(rpt_n), .debounce_discharge(dis)
  );

  kme_matrix_model keys (
    .matrix_drive_lines(drive), .key_mask(key_mask), .matrix_sense_lines(sense)
  );

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clock) timing_pulse = 1'b1;
      repeat (4) @(negedge clock);
      timing_pulse = 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask

  task automatic key_test(input int d, input int s, input logic [7:0] mask, input logic [7:0] exp);
    int i;
    key_mask = '0;
    key_mask[d*8+s] = 1'b1;
    i = 0;
    while (rdy_n !== 1'b0 && i < 200) begin
      pulses(1);
      i++;
    end
    chk(11'(rdy_n), 11'h0);
    chk(drive, 11'h1 << d);
    chk(11'(dis), 11'h1);
    // A later key in the scan order is pressed too
    key_mask[((d+1)%11)*8+s] = 1'b1;
    pulses(3);
    chk(drive, 11'h1 << d);
    chk(11'(doe), 11'h0);
    cs = 4'h7;
    repeat (2) @(negedge clock);
    chk(11'(doe), 11'h0);
    timing_pulse = 1'b1;
    repeat (4) @(negedge clock);
    chk(11'(rdy_n), 11'h0);
    timing_pulse = 1'b0;
    @(negedge clock);
    cs = 4'hf;
    repeat (2) @(negedge clock);
    chk(11'(doe), 11'h0ff);
    chk(11'(dout & mask), 11'(exp));
    timing_pulse = 1'b1;
    repeat (4) @(negedge clock);
    chk(11'(rdy_n), 11'h1);
    chk(11'(rpt_n), 11'h0);
    cs = 4'h0;
    pulses(4);
    chk(11'(rdy_n), 11'h1);
    chk(11'(rpt_n), 11'h0);
    chk(drive, 11'h1 << d);
    key_mask = '0;
    i = 0;
    while (rpt_n !== 1'b1 && i < 50) begin
      pulses(1);
      i++;
    end
    chk(11'(rpt_n), 11'h1);
    chk(11'(dis), 11'h0);
    i = 0;
    while (drive === (11'h1 << d) && i < 20) begin
      pulses(1);
      i++;
    end
    chk(11'(drive === (11'h1 << d)), 11'h0);
  endtask

  // Key let go before the host reads it
  task automatic release_first(input int d, input int s);
    int i;
    key_mask = '0;
    key_mask[d*8+s] = 1'b1;
    i = 0;
    while (rdy_n !== 1'b0 && i < 200) begin
      pulses(1);
      i++;
    end
    chk(11'(rdy_n), 11'h0);
    key_mask = '0;
    pulses(6);
    chk(11'(rpt_n), 11'h1);
    chk(11'(dis), 11'h0);
    chk(11'(rdy_n), 11'h0);
    chk(drive, 11'h1 << d);
    cs = 4'hf;
    repeat (2) @(negedge clock);
    timing_pulse = 1'b1;
    repeat (4) @(negedge clock);
    chk(11'(rdy_n), 11'h1);
    chk(11'(rpt_n), 11'h1);
    cs = 4'h0;
    i = 0;
    while (drive === (11'h1 << d) && i < 20) begin
      pulses(1);
      i++;
    end
    chk(11'(drive === (11'h1 << d)), 11'h0);
  endtask

  initial begin
    #(25 * 20000);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (16) @(negedge clock);
    chk(drive, 11'h001);
    chk({doe, rdy_n, rpt_n, dis}, 11'h006);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    // Modifiers alone never raise a key
    shift_in = 1'b1;
    control_in = 1'b1;
    alpha_in = 1'b1;
    seen_or = '0;
    repeat (100) begin
      pulses(1);
      seen_or = seen_or | drive;
      chk(11'($countones(drive)), 11'h1);
    end
    chk(seen_or, 11'h7ff);
    chk(11'(rdy_n), 11'h1);
    shift_in = 1'b0;
    control_in = 1'b0;
    alpha_in = 1'b0;
    pulses(2);
    key_test(2, 3, 8'h80, 8'h00);
    key_test(7, 0, 8'hff, 8'h80);
    key_test(8, 5, 8'hff, 8'h8d);
    release_first(4, 6);
    summarize();
  end
endmodule
`default_nettype wire
